/* src/qec_counter.sv */
// Purpose: Quadrature decoder and position counter with APB registers
// Assumes: Encoder and sample clock pins are asynchronous to pclk
// Notes:   One-cycle APB answer; count is signed two's complement
`timescale 1ns/1ps
`include "qec_defines.svh"
module qec_counter
  import qec_pkg::*;
(
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Encoder pins: A, B, index
  input  wire logic                  primary_counter_pin,
  input  wire logic                  auxiliary_counter_pin,
  input  wire logic                  gating_counter_pin,
  // Acquisition sample clock pin
  input  wire logic                  sample_clk_pin,
  // Captured position
  output logic      [`QEC_CNT_W-1:0] position_sample
);

  logic [`QEC_CTRL_W-1:0] ctrl;
  logic [`QEC_CTRL_W-1:0] next_ctrl;
  logic [`QEC_CNT_W-1:0]  count;
  logic [`QEC_CNT_W-1:0]  next_count;
  logic [`QEC_CNT_W-1:0]  next_position_sample;
  logic [31:0]            next_prdata;
  logic                   next_pready;
  logic                   next_pslverr;
  logic [3:0]             sync1;
  logic [3:0]             sync2;
  logic [2:0]             filt;
  logic [2:0]             inv;
  logic [2:0]             cur;
  logic [2:0]             prev;
  logic                   samp_prev;
  logic                   acq_start;
  logic                   a_chg;
  logic                   b_chg;
  logic                   up_dir;
  logic                   index_hit;
  logic                   do_up;
  logic                   do_down;
  qec_mode_t              mode;

  assign mode = qec_mode_t'(ctrl[`QEC_MODE_HI:`QEC_MODE_LO]);
  assign inv  = {ctrl[`QEC_INV_Z], ctrl[`QEC_INV_B], ctrl[`QEC_INV_A]};

  // Two-flop synchronisers for all pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {sample_clk_pin, gating_counter_pin, auxiliary_counter_pin, primary_counter_pin};
      sync2 <= sync1;
    end
  end

  // One glitch filter per encoder input
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      qec_filter u_filt (
        .pclk     (pclk),
        .presetn  (presetn),
        .gate_sel (ctrl[`QEC_FILT_HI:`QEC_FILT_LO]),
        .raw      (sync2[gi]),
        .filt     (filt[gi])
      );
    end
  endgenerate

  // Inversion turns falling edges into active edges
  assign cur = filt ^ inv;

  // Edge history for decoding and sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev      <= 3'h0;
      samp_prev <= 1'b0;
    end else begin
      prev      <= cur;
      samp_prev <= sync2[3];
    end
  end

  // Edge and direction terms; A leads B gives up
  always_comb begin
    a_chg     = cur[0] != prev[0];
    b_chg     = cur[1] != prev[1];
    up_dir    = cur[0] ^ prev[1];
    index_hit = cur[2] && !cur[0] && !cur[1];
    do_up     = 1'b0;
    do_down   = 1'b0;
    case (mode)
      single_edge_decoding: begin
        // Only A edges with B low: rise counts up, fall counts down
        do_up   = a_chg && !b_chg && !cur[1] && cur[0];
        do_down = a_chg && !b_chg && !cur[1] && !cur[0];
      end
      double_edge_decoding: begin
        do_up   = a_chg && !b_chg && up_dir;
        do_down = a_chg && !b_chg && !up_dir;
      end
      quad_edge_decoding: begin
        // Both phases moving at once is illegal and ignored
        do_up   = (a_chg ^ b_chg) && up_dir;
        do_down = (a_chg ^ b_chg) && !up_dir;
      end
      updown_decoding: begin
        // Two-output encoder; simultaneous pulses cancel
        do_up   = a_chg && cur[0] && !(b_chg && cur[1]);
        do_down = b_chg && cur[1] && !(a_chg && cur[0]);
      end
      default: begin
        do_up   = 1'b0;
        do_down = 1'b0;
      end
    endcase
  end

  // Acquisition start is the rising write of the acquire bit
  assign acq_start = next_ctrl[`QEC_ACQ] && !ctrl[`QEC_ACQ];

  // Count: start clear and index reload beat counting
  always_comb begin
    next_count = count;
    if (acq_start && ctrl[`QEC_RST_START]) begin
      next_count = `QEC_CNT_ZERO;
    end else if (index_hit) begin
      next_count = `QEC_CNT_ZERO;
    end else if (do_up) begin
      next_count = count + `QEC_CNT_ONE;
    end else if (do_down) begin
      next_count = count - `QEC_CNT_ONE;
    end
  end

  // Capture count on each sample clock rising edge
  always_comb begin
    next_position_sample = position_sample;
    if (sync2[3] && !samp_prev) begin
      next_position_sample = count;
    end
  end

  // APB: decode at setup, answer ready in the access cycle
  always_comb begin
    next_ctrl    = ctrl;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      case (paddr)
        `QEC_OFS_CTRL:   next_prdata = {{(32-`QEC_CTRL_W){1'b0}}, ctrl};
        `QEC_OFS_COUNT:  next_prdata = count;
        `QEC_OFS_SAMPLE: next_prdata = position_sample;
        default: begin
          next_prdata  = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // Write lands only at the completing access edge
    if (psel && penable && pready && pwrite && paddr == `QEC_OFS_CTRL) begin
      next_ctrl = pwdata[`QEC_CTRL_W-1:0];
    end
  end

  // Register stage for control, count and bus outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl            <= `QEC_CTRL_RESET;
      count           <= `QEC_CNT_ZERO;
      position_sample <= `QEC_CNT_ZERO;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      ctrl            <= next_ctrl;
      count           <= next_count;
      position_sample <= next_position_sample;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
    end
  end

  a_index_reload_zero: assert property (@(posedge pclk) disable iff (!presetn)
    index_hit |=> (count == `QEC_CNT_ZERO))
    else $error("index in reload phase did not zero the count");

  a_illegal_both_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == quad_edge_decoding && a_chg && b_chg && !index_hit && !acq_start) |=> $stable(count))
    else $error("count moved on an illegal double transition");

  a_single_rise_up: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == single_edge_decoding && a_chg && cur[0] && !b_chg && !cur[1] && !index_hit && !acq_start)
    |=> (count == $past(count) + `QEC_CNT_ONE))
    else $error("single edge rise of A did not count up");

  a_single_fall_down: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == single_edge_decoding && a_chg && !cur[0] && !b_chg && !cur[1] && !index_hit && !acq_start)
    |=> (count == $past(count) - `QEC_CNT_ONE))
    else $error("single edge fall of A did not count down");

  a_double_a_moves: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == double_edge_decoding && a_chg && !b_chg && !index_hit && !acq_start)
    |=> (count != $past(count)))
    else $error("double edge A transition left count unchanged");

  a_quad_b_moves: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == quad_edge_decoding && b_chg && !a_chg && !index_hit && !acq_start)
    |=> (count != $past(count)))
    else $error("quad edge B transition left count unchanged");

  a_updown_b_down: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == updown_decoding && b_chg && cur[1] && !a_chg && !index_hit && !acq_start)
    |=> (count == $past(count) - `QEC_CNT_ONE))
    else $error("rising B in up/down mode did not count down");

  a_sample_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (sync2[3] && !samp_prev) |=> (position_sample == $past(count)))
    else $error("sample clock did not capture the count");

  a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (acq_start && ctrl[`QEC_RST_START]) |=> (count == `QEC_CNT_ZERO))
    else $error("acquisition start did not clear the count");

  c_quad_up: cover property (@(posedge pclk) disable iff (!presetn)
    mode == quad_edge_decoding && do_up);
  c_single_down: cover property (@(posedge pclk) disable iff (!presetn)
    mode == single_edge_decoding && do_down);
  c_index_reload: cover property (@(posedge pclk) disable iff (!presetn)
    index_hit && count != `QEC_CNT_ZERO);
  c_sample_taken: cover property (@(posedge pclk) disable iff (!presetn)
    sync2[3] && !samp_prev);

endmodule

/* src/qec_defines.svh */
// Purpose: Constants for the quadrature encoder counter
// Assumes: pclk at 10 MHz, APB word registers
// Notes:   Offsets, fields, resets and filter gate times
`ifndef QEC_DEFINES_SVH
`define QEC_DEFINES_SVH

// Register byte offsets
`define QEC_OFS_CTRL     8'h00
`define QEC_OFS_COUNT    8'h04
`define QEC_OFS_SAMPLE   8'h08

// Control field positions
`define QEC_MODE_LO      0
`define QEC_MODE_HI      1
`define QEC_FILT_LO      2
`define QEC_FILT_HI      4
`define QEC_INV_A        5
`define QEC_INV_B        6
`define QEC_INV_Z        7
`define QEC_RST_START    8
`define QEC_ACQ          9
`define QEC_CTRL_W       10
`define QEC_CTRL_RESET   10'h100

// Widths and reset values
`define QEC_CNT_W        32
`define QEC_CNT_ZERO     32'h0000_0000
`define QEC_CNT_ONE      32'h0000_0001
`define QEC_FCNT_W       6
`define QEC_FCNT_ZERO    6'h00
`define QEC_FCNT_ONE     6'h01

// Filter gate times in ns, clock period in ns
`define QEC_CLK_NS       100
`define QEC_GATE0_NS     0
`define QEC_GATE1_NS     100
`define QEC_GATE2_NS     200
`define QEC_GATE3_NS     500
`define QEC_GATE4_NS     1000
`define QEC_GATE5_NS     2000
`define QEC_GATE6_NS     4000
`define QEC_GATE7_NS     5000
`define QEC_CYC(ns)      (((ns) + `QEC_CLK_NS - 1) / `QEC_CLK_NS)

`endif

/* src/qec_filter.sv */
// Purpose: Digital glitch filter for one encoder input
// Assumes: Input already synchronised to pclk
// Notes:   Gate time zero passes the level through one flop
`timescale 1ns/1ps
`include "qec_defines.svh"
module qec_filter
  import qec_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Filter control and data
  input  wire logic [2:0] gate_sel,
  input  wire logic       raw,
  output logic            filt
);

  logic [`QEC_FCNT_W-1:0] hold_cnt;
  logic [`QEC_FCNT_W-1:0] next_hold_cnt;
  logic                   next_filt;
  logic [`QEC_FCNT_W-1:0] gate_cyc;

  // Gate time in cycles, rounded up
  always_comb begin
    case (gate_sel)
      3'h0:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE0_NS));
      3'h1:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE1_NS));
      3'h2:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE2_NS));
      3'h3:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE3_NS));
      3'h4:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE4_NS));
      3'h5:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE5_NS));
      3'h6:    gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE6_NS));
      default: gate_cyc = `QEC_FCNT_W'(`QEC_CYC(`QEC_GATE7_NS));
    endcase
  end

  // New level passes only after holding for the gate time
  always_comb begin
    next_filt     = filt;
    next_hold_cnt = `QEC_FCNT_ZERO;
    if (gate_cyc == `QEC_FCNT_ZERO) begin
      next_filt = raw;
    end else if (raw != filt) begin
      if (hold_cnt + `QEC_FCNT_ONE >= gate_cyc) begin
        next_filt = raw;
      end else begin
        next_hold_cnt = hold_cnt + `QEC_FCNT_ONE;
      end
    end
  end

  // Filter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt     <= 1'b0;
      hold_cnt <= `QEC_FCNT_ZERO;
    end else begin
      filt     <= next_filt;
      hold_cnt <= next_hold_cnt;
    end
  end

  a_filter_hold_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (filt != $past(filt)) |-> ($past(raw) == filt))
    else $error("filter output changed to a level the input did not have");

endmodule

/* src/qec_pkg.sv */
// Purpose: Types for the quadrature encoder counter
// Assumes: Constants come from qec_defines.svh
// Notes:   Mode order matches the control register field
package qec_pkg;
  // Decoding mode, in control field order
  typedef enum logic [1:0] {
    single_edge_decoding,
    double_edge_decoding,
    quad_edge_decoding,
    updown_decoding
  } qec_mode_t;
endpackage

/* verif/qec_encoder_model.sv */
// Purpose: Behavioural rotary encoder driving A, B and index
// Assumes: Bench requests one quarter-cycle step at a time
// Notes:   Skip flips both phases, an illegal jump on request
`timescale 1ns/1ps
module qec_encoder_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Motion requests from the bench
  input  wire logic step,
  input  wire logic fwd,
  input  wire logic two_out,
  input  wire logic skip,
  input  wire logic index,
  // Encoder lines, always driven
  output logic      a,
  output logic      b,
  output logic      z
);
  logic next_a, next_b, next_z;

  // Gray walk keeps A a quarter cycle ahead of B going forward
  always_comb begin
    next_a = a;
    next_b = b;
    if (skip) begin
      next_a = !a;
      next_b = !b;
    end else if (step && two_out) begin
      next_a = fwd ? !a : a;
      next_b = fwd ? b : !b;
    end else if (step) begin
      next_a = fwd ? !b : b;
      next_b = fwd ? a : !a;
    end
    next_z = index && !next_a && !next_b;
  end

  // Lines change only on the clock, like a sampled encoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a <= 1'b0;
      b <= 1'b0;
      z <= 1'b0;
    end else begin
      a <= next_a;
      b <= next_b;
      z <= next_z;
    end
  end
endmodule

/* verif/quadrature_encoder_counter_bench.sv */
// Purpose: Self-checking bench for the encoder counter
// Assumes: Counter raises pready when it answers; bench waits for it
// Notes:   Random moves from a fixed xorshift seed
`timescale 1ns/1ps
`include "qec_defines.svh"
module quadrature_encoder_counter_bench
  import qec_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        a, b, z, smp, step, fwd, skip, index, er, two_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, exp_cnt, e0, rng, position_sample;
  int          err_count = 0, tests_run = 0, cyc = 0;
  qec_mode_t   mode;

  assign two_out = (mode == updown_decoding);

  qec_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_counter_pin(a), .auxiliary_counter_pin(b), .gating_counter_pin(z),
    .sample_clk_pin(smp), .position_sample(position_sample));
  qec_encoder_model enc (.pclk(pclk), .presetn(presetn), .step(step), .fwd(fwd),
    .two_out(two_out), .skip(skip), .index(index), .a(a), .b(b), .z(z));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected count change for one pin transition
  function automatic logic [31:0] delta(input qec_mode_t m, input logic pa, pb, na, nb);
    logic up;
    up = na ^ pb;
    if (m == updown_decoding)
      return ((na & !pa) == (nb & !pb)) ? 32'h0 : ((na & !pa) ? 32'h1 : 32'hFFFF_FFFF);
    if ((pa ^ na) & (pb ^ nb))
      return 32'h0;
    if (m == quad_edge_decoding && (pa ^ na | pb ^ nb))
      return up ? 32'h1 : 32'hFFFF_FFFF;
    if (pa ^ na && (m == double_edge_decoding || !nb))
      return up ? 32'h1 : 32'hFFFF_FFFF;
    return 32'h0;
  endfunction

  // Invert bits in {index, B, A} order
  function automatic logic [31:0] ctl(input logic [2:0] f, input logic [2:0] iv, input logic rs, ac);
    return {22'h0, ac, rs, iv, f, mode};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are the slave's choice; pready ends this wait, or the hang guard if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_count();
    apb(1'b0, `QEC_OFS_COUNT, 32'h0);
    chk("count", exp_cnt, rd);
    chk("count_err", 32'h0, {31'h0, er});
  endtask

  // Acquire off then on, so a clear can take place
  task automatic start(input logic rs, input logic [2:0] f, input logic [2:0] iv);
    apb(1'b1, `QEC_OFS_CTRL, ctl(f, iv, rs, 1'b0));
    apb(1'b1, `QEC_OFS_CTRL, ctl(f, iv, rs, 1'b1));
    if (rs) exp_cnt = 32'h0;
    apb(1'b0, `QEC_OFS_CTRL, 32'h0);
    chk("ctrl", ctl(f, iv, rs, 1'b1), rd);
  endtask

  task automatic move(input logic f, input logic sk, input int g);
    logic pa, pb;
    pa = a;
    pb = b;
    @(posedge pclk);
    fwd <= f;
    step <= !sk;
    skip <= sk;
    @(posedge pclk);
    step <= 1'b0;
    skip <= 1'b0;
    repeat (g) @(posedge pclk);
    exp_cnt = exp_cnt + delta(mode, pa, pb, a, b);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, smp, step, fwd, skip, index} = 9'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    exp_cnt = 32'h0;
    rng = 32'h1E;
    mode = single_edge_decoding;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value, unmapped address, read-only count
    apb(1'b0, `QEC_OFS_CTRL, 32'h0);
    chk("ctrl_reset", 32'h100, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("bad_err", 32'h1, {31'h0, er});
    apb(1'b1, `QEC_OFS_COUNT, 32'h5A);
    rd_count();
    // Random walk in every decoding mode, with illegal jumps
    for (int m = 0; m < 4; m++) begin
      mode = qec_mode_t'(m);
      start(1'b1, 3'h0, 3'h0);
      repeat (24) begin
        rng = xs(rng);
        move(rng[0], rng[4:1] == 4'h0, 10);
        rd_count();
      end
    end
    // Index reload at the all-low phase, then counting resumes
    mode = quad_edge_decoding;
    start(1'b0, 3'h0, 3'h0);
    repeat (2) move(1'b1, 1'b0, 10);
    while (a | b) move(1'b1, 1'b0, 10);
    index <= 1'b1;
    repeat (10) @(posedge pclk);
    exp_cnt = 32'h0;
    rd_count();
    index <= 1'b0;
    move(1'b1, 1'b0, 10);
    rd_count();
    // Capture holds while the live count moves on
    smp <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("sample_pin", exp_cnt, position_sample);
    smp <= 1'b0;
    move(1'b1, 1'b0, 10);
    apb(1'b0, `QEC_OFS_SAMPLE, 32'h0);
    chk("sample_reg", exp_cnt - 32'h1, rd);
    // Restart keeps the count, then clears it
    start(1'b0, 3'h0, 3'h0);
    rd_count();
    start(1'b1, 3'h0, 3'h0);
    rd_count();
    // Every gate time passes a long pulse
    mode = updown_decoding;
    for (int f = 0; f < 8; f++) begin
      start(1'b0, 3'(f), 3'h0);
      repeat (2) move(1'b1, 1'b0, 60);
      rd_count();
    end
    // Short pulse dies in a 500 ns gate
    start(1'b0, 3'h3, 3'h0);
    e0 = exp_cnt;
    move(1'b1, 1'b0, 2);
    move(1'b1, 1'b0, 20);
    exp_cnt = e0;
    rd_count();
    // Inverted A counts on the falling pin
    if (!a) move(1'b1, 1'b0, 20);
    start(1'b0, 3'h0, 3'h1);
    e0 = exp_cnt;
    move(1'b1, 1'b0, 20);
    exp_cnt = e0 + 32'h1;
    rd_count();
    // Inverted B counts down on the falling pin
    if (!b) move(1'b0, 1'b0, 20);
    start(1'b0, 3'h0, 3'h2);
    e0 = exp_cnt;
    move(1'b0, 1'b0, 20);
    exp_cnt = e0 - 32'h1;
    rd_count();
    // Inverted index is active while its pin is low, so all-low phase reloads
    mode = quad_edge_decoding;
    start(1'b0, 3'h0, 3'h4);
    exp_cnt = 32'h0;
    move(1'b1, 1'b0, 10);
    rd_count();
    while (a | b) move(1'b1, 1'b0, 10);
    exp_cnt = 32'h0;
    rd_count();
    end_of_test();
  end
endmodule
